// ===== hdl/peu_pkg.sv
package peu_pkg;
  // ===========================================================================
  // widths
  localparam int PEU_AW = 32;
  localparam int PEU_MSR_W = 32;
  // ===========================================================================
  // machine state register field positions (neutral layout)
  localparam int PEU_MSR_EE_POS = 15;
  localparam int PEU_MSR_IP_POS = 6;
  localparam int PEU_MSR_RI_POS = 1;
  localparam logic [PEU_MSR_W-1:0] PEU_MSR_RESET = 32'h0000_0040;
  // ===========================================================================
  // vector bases and offsets
  localparam logic [PEU_AW-1:0] PEU_BASE_LOW = 32'h0000_0000;
  localparam logic [PEU_AW-1:0] PEU_BASE_HIGH = 32'hfff0_0000;
  localparam logic [PEU_AW-1:0] PEU_PC_STEP = 32'h0000_0004;
  localparam logic [PEU_AW-1:0] PEU_VEC_RESET = 32'h0000_0100;
  localparam logic [PEU_AW-1:0] PEU_VEC_MCHK = 32'h0000_0200;
  localparam logic [PEU_AW-1:0] PEU_VEC_EXT = 32'h0000_0500;
  // offsets beyond the three fixed ones are inputs of the top module
  // ===========================================================================
  // synchronous cause codes
  typedef enum logic [3:0] {
    PEU_SC_MCHK, PEU_SC_ALIGN, PEU_SC_ALIGN_MULT, PEU_SC_PRIV, PEU_SC_TRAP,
    PEU_SC_FPUNAV, PEU_SC_IBRK, PEU_SC_SWEMU, PEU_SC_FPASSIST, PEU_SC_FPEN_FP_STATUS_CONTROL_REGISTER,
    PEU_SC_FPEN_MSR, PEU_SC_SYSCALL, PEU_SC_TRACE, PEU_SC_LBRK
  } peu_sync_cause_t;
  // pc selection kinds
  typedef enum logic [1:0] {
    PEU_PC_FAULT, PEU_PC_NEXT, PEU_PC_PLUS4
  } peu_pc_kind_t;
  // taken classes
  typedef enum logic [2:0] {
    PEU_TK_NONE, PEU_TK_RESET, PEU_TK_NMBRK, PEU_TK_SYNC, PEU_TK_EXT, PEU_TK_DEC, PEU_TK_MBRK
  } peu_take_t;
endpackage

// ===== hdl/peu_async_latch.sv
`timescale 1ns/100ps
`default_nettype none
// ===========================================================================
// pending latch for one asynchronous request; pin sampled by two flops
module peu_async_latch
  import peu_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  input  wire logic req_pin_in,
  input  wire logic clear_in,
  output logic      pending_out
);
  logic sync1;
  logic sync2;
  logic pend;
  logic next_pend;

  // set beats clear so an arrival in the acknowledge cycle survives
  always_comb begin
    next_pend = pend;
    if (clear_in) begin
      next_pend = 1'b0;
    end
    if (sync2) begin
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      pend <= 1'b0;
    end else begin
      sync1 <= req_pin_in;
      sync2 <= sync1;
      pend <= next_pend;
    end
  end

  assign pending_out = pend;
endmodule // peu_async_latch
`default_nettype wire

// ===== hdl/peu_core.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// RL1 - instruction faults precise, back up pipeline
// RL2 - flush younger, older ones appear completed
// RL3 - saved pc faulting or next by type
// RL4 - before-execution faults save faulting address
// RL5 - multiple alignment partial, saves faulting address
// RL6 - syscall, trace, msr-move fp save next
// RL7 - data breakpoint saves faulting address plus four
// RL8 - machine check attributed to its instruction
// RL9 - async saves next completing instruction
// RL10 - four maskable async sources supported; the core has three: ext, dec and maskable breakpoint
// RL11 - ext/dec latched while enable bit clear
// RL12 - any taken exception clears enable bit
// RL13 - maskable breakpoints need recoverable bit set
// RL14 - reset, nonmaskable breakpoints never delayed
// RL15 - nonmaskable ones may overwrite saved state
// RL16 - handler is selected base plus offset
// RL17 - recoverable bit copied into saved state
// RL18 - fixed offsets for reset, mchk, ext
// RL19 - priority nonmaskable, synchronous, then maskable
module peu_core
  import peu_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 reset_req_in,
  input  wire logic                 nm_brk_in,
  input  wire logic                 ext_irq_in,
  input  wire logic                 dec_irq_in,
  input  wire logic                 m_brk_in,
  input  wire logic                 sync_valid_in,
  input  wire peu_sync_cause_t      sync_cause_in,
  input  wire logic [PEU_AW-1:0]    sync_pc_in,
  input  wire logic [PEU_AW-1:0]    next_pc_in,
  input  wire logic [PEU_AW-1:0]    sync_vec_in,
  input  wire logic [PEU_AW-1:0]    dec_vec_in,
  input  wire logic [PEU_AW-1:0]    brk_vec_in,
  input  wire logic                 head_ready_in,
  input  wire logic                 msr_wr_in,
  input  wire logic [PEU_MSR_W-1:0] msr_wdata_in,
  output logic                      take_out,
  output logic                      flush_out,
  output logic [PEU_AW-1:0]         handler_addr_out,
  output logic [PEU_AW-1:0]         saved_program_counter_out,
  output logic [PEU_MSR_W-1:0]      saved_machine_state_out,
  output logic [PEU_MSR_W-1:0]      machine_state_register_out,
  output logic                      ext_pending_out,
  output logic                      dec_pending_out
);
  // every check samples on the core clock and sleeps during reset
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ===========================================================================
  // pending latches (ext, dec) and two-flop request synchronizers
  logic ext_pend;
  logic dec_pend;
  logic ext_clr;
  logic dec_clr;
  logic rst_req;
  logic rst_s1;
  logic nm_s1;
  logic nm_req;
  logic mb_s1;
  logic mb_req;

  peu_async_latch u_ext (
    .sys_clk_in  (sys_clk_in),
    .resetn_in   (resetn_in),
    .req_pin_in  (ext_irq_in),
    .clear_in    (ext_clr),
    .pending_out (ext_pend)
  ); // RL11

  peu_async_latch u_dec (
    .sys_clk_in  (sys_clk_in),
    .resetn_in   (resetn_in),
    .req_pin_in  (dec_irq_in),
    .clear_in    (dec_clr),
    .pending_out (dec_pend)
  ); // RL11

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1 <= 1'b0;
      rst_req <= 1'b0;
      nm_s1 <= 1'b0;
      nm_req <= 1'b0;
      mb_s1 <= 1'b0;
      mb_req <= 1'b0;
    end else begin
      rst_s1 <= reset_req_in;
      rst_req <= rst_s1;
      nm_s1 <= nm_brk_in;
      nm_req <= nm_s1;
      mb_s1 <= m_brk_in;
      mb_req <= mb_s1;
    end
  end

  // ===========================================================================
  // selection
  logic [PEU_MSR_W-1:0] machine_state_register;
  logic [PEU_MSR_W-1:0] next_msr;
  logic [PEU_AW-1:0]    saved_program_counter;
  logic [PEU_AW-1:0]    next_saved_program_counter;
  logic [PEU_MSR_W-1:0] saved_machine_state;
  logic [PEU_MSR_W-1:0] next_saved_machine_state;
  logic [PEU_AW-1:0]    haddr;
  logic [PEU_AW-1:0]    next_haddr;
  logic                 take;
  logic                 next_take;
  logic                 flush;
  logic                 next_flush;
  peu_take_t            sel;
  logic [PEU_AW-1:0]    off;
  logic [PEU_AW-1:0]    base;
  logic                 ee;
  logic                 ri;

  function automatic peu_pc_kind_t pc_kind(input peu_sync_cause_t c);
    case (c)
      PEU_SC_FPEN_MSR, PEU_SC_SYSCALL, PEU_SC_TRACE: pc_kind = PEU_PC_NEXT; // RL6
      PEU_SC_LBRK: pc_kind = PEU_PC_PLUS4; // RL7
      default: pc_kind = PEU_PC_FAULT; // RL4 RL5 RL8
    endcase
  endfunction

  function automatic logic [PEU_AW-1:0] saved_pc(input peu_sync_cause_t c,
                                                  input logic [PEU_AW-1:0] fpc,
                                                  input logic [PEU_AW-1:0] npc);
    case (pc_kind(c))
      PEU_PC_NEXT: saved_pc = npc;
      PEU_PC_PLUS4: saved_pc = fpc + PEU_PC_STEP;
      default: saved_pc = fpc;
    endcase
  endfunction

  assign ee = machine_state_register[PEU_MSR_EE_POS];
  assign ri = machine_state_register[PEU_MSR_RI_POS];
  assign base = machine_state_register[PEU_MSR_IP_POS] ? PEU_BASE_HIGH : PEU_BASE_LOW; // RL16

  // priority: nonmaskable first, never waits for head of history
  always_comb begin
    sel = PEU_TK_NONE;
    if (rst_req) begin
      sel = PEU_TK_RESET; // RL14 RL19
    end else if (nm_req) begin
      sel = PEU_TK_NMBRK; // RL14 RL15
    end else if (sync_valid_in) begin
      sel = PEU_TK_SYNC; // RL1 RL19
    end else if (head_ready_in && ee && ext_pend) begin
      sel = PEU_TK_EXT; // RL10 RL11
    end else if (head_ready_in && ee && dec_pend) begin
      sel = PEU_TK_DEC; // RL10 RL11
    end else if (head_ready_in && ri && mb_req) begin
      sel = PEU_TK_MBRK; // RL13
    end
  end

  always_comb begin
    case (sel)
      PEU_TK_RESET: off = PEU_VEC_RESET; // RL18
      PEU_TK_SYNC: off = (sync_cause_in == PEU_SC_MCHK) ? PEU_VEC_MCHK : sync_vec_in; // RL18
      PEU_TK_EXT: off = PEU_VEC_EXT; // RL18
      PEU_TK_DEC: off = dec_vec_in;
      PEU_TK_NMBRK, PEU_TK_MBRK: off = brk_vec_in;
      default: off = '0;
    endcase
  end

  assign ext_clr = (sel == PEU_TK_EXT);
  assign dec_clr = (sel == PEU_TK_DEC);

  always_comb begin
    next_msr = machine_state_register;
    next_saved_program_counter = saved_program_counter;
    next_saved_machine_state = saved_machine_state;
    next_haddr = haddr;
    next_take = 1'b0;
    next_flush = 1'b0;
    if (msr_wr_in) begin
      next_msr = msr_wdata_in;
    end
    if (sel != PEU_TK_NONE) begin
      next_take = 1'b1;
      next_flush = 1'b1; // RL2
      next_haddr = base + off; // RL16
      next_saved_machine_state = machine_state_register; // RL17
      next_msr[PEU_MSR_EE_POS] = 1'b0; // RL12
      if (sel == PEU_TK_SYNC) begin
        next_saved_program_counter = saved_pc(sync_cause_in, sync_pc_in, next_pc_in); // RL3
      end else begin
        next_saved_program_counter = next_pc_in; // RL9
      end
    end
  end

  // saved state overwritten even mid-handler: nonmaskable cannot wait
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      machine_state_register <= PEU_MSR_RESET;
      saved_program_counter <= '0;
      saved_machine_state <= '0;
      haddr <= '0;
      take <= 1'b0;
      flush <= 1'b0;
    end else begin
      machine_state_register <= next_msr;
      saved_program_counter <= next_saved_program_counter;
      saved_machine_state <= next_saved_machine_state;
      haddr <= next_haddr;
      take <= next_take;
      flush <= next_flush;
    end
  end

  assign take_out = take;
  assign flush_out = flush;
  assign handler_addr_out = haddr;
  assign saved_program_counter_out = saved_program_counter;
  assign saved_machine_state_out = saved_machine_state;
  assign machine_state_register_out = machine_state_register;
  assign ext_pending_out = ext_pend;
  assign dec_pending_out = dec_pend;

  // ===========================================================================
  // checks
  // a take clears the enable bit even when software writes the register
  a_ee_cleared: assert property (sel != PEU_TK_NONE |=> !machine_state_register[PEU_MSR_EE_POS]) // RL12
    else $error("enable bit not cleared on take");
  a_ext_masked: assert property (!ee |-> sel != PEU_TK_EXT && sel != PEU_TK_DEC) // RL11
    else $error("masked interrupt taken");
  a_ext_held: assert property (ext_pend && !ee |=> ext_pend) // RL11
    else $error("pending interrupt lost");
  a_dec_held: assert property (dec_pend && !ee |=> dec_pend) // RL11
    else $error("pending decrementer lost");
  a_msr_write: assert property (msr_wr_in && sel == PEU_TK_NONE // RL11
    |=> machine_state_register == $past(msr_wdata_in))
    else $error("state register write lost");
  a_mbrk_ri: assert property (sel == PEU_TK_MBRK |-> ri) // RL13
    else $error("breakpoint taken without recoverable bit");
  // maskable sources wait for the head, or older work would look lost
  a_head_gate: assert property (!head_ready_in // RL9
    |-> !(sel inside {PEU_TK_EXT, PEU_TK_DEC, PEU_TK_MBRK}))
    else $error("maskable exception taken before head ready");

  // ordering
  a_rst_first: assert property (rst_req |-> sel == PEU_TK_RESET) // RL14
    else $error("reset request delayed");
  a_nm_first: assert property (nm_req && !rst_req |-> sel == PEU_TK_NMBRK) // RL14
    else $error("nonmaskable breakpoint delayed");
  a_sync_order: assert property (sync_valid_in && !rst_req && !nm_req // RL19
    |-> sel == PEU_TK_SYNC)
    else $error("instruction fault not taken first");

  // saved program counter
  a_lbrk_pc: assert property (sel == PEU_TK_SYNC && sync_cause_in == PEU_SC_LBRK // RL7
    |=> saved_program_counter == $past(sync_pc_in) + PEU_PC_STEP)
    else $error("data breakpoint pc wrong");
  a_sc_pc: assert property (sel == PEU_TK_SYNC && sync_cause_in == PEU_SC_SYSCALL // RL6
    |=> saved_program_counter == $past(next_pc_in))
    else $error("system call pc wrong");
  a_next_pc: assert property (sel == PEU_TK_SYNC // RL6
    && sync_cause_in inside {PEU_SC_FPEN_MSR, PEU_SC_TRACE} |=> saved_program_counter == $past(next_pc_in))
    else $error("after-execution pc wrong");
  a_fault_pc: assert property (sel == PEU_TK_SYNC // RL4 RL5
    && sync_cause_in inside {PEU_SC_ALIGN, PEU_SC_ALIGN_MULT, PEU_SC_PRIV, PEU_SC_TRAP,
    PEU_SC_FPUNAV, PEU_SC_IBRK, PEU_SC_SWEMU, PEU_SC_FPASSIST, PEU_SC_FPEN_FP_STATUS_CONTROL_REGISTER}
    |=> saved_program_counter == $past(sync_pc_in))
    else $error("before-execution pc wrong");
  a_mchk_pc: assert property (sel == PEU_TK_SYNC && sync_cause_in == PEU_SC_MCHK // RL8 RL4
    |=> saved_program_counter == $past(sync_pc_in) && haddr == $past(base) + PEU_VEC_MCHK)
    else $error("machine check save wrong");
  a_async_pc: assert property (sel inside {PEU_TK_RESET, PEU_TK_NMBRK, PEU_TK_EXT, // RL9
    PEU_TK_DEC, PEU_TK_MBRK} |=> saved_program_counter == $past(next_pc_in))
    else $error("asynchronous pc wrong");

  // saved state and vectors
  a_ri_copy: assert property (take // RL17
    |-> saved_machine_state[PEU_MSR_RI_POS] == $past(machine_state_register[PEU_MSR_RI_POS]))
    else $error("recoverable bit not copied");
  a_saved_machine_state_copy: assert property (sel != PEU_TK_NONE // RL17
    |=> saved_machine_state == $past(machine_state_register))
    else $error("saved state not copied");
  a_ext_vec: assert property (sel == PEU_TK_EXT // RL16 RL18
    |=> take && flush && haddr == $past(base) + PEU_VEC_EXT)
    else $error("external vector wrong");
  a_rst_vec: assert property (sel == PEU_TK_RESET // RL18
    |=> haddr == $past(base) + PEU_VEC_RESET)
    else $error("reset vector wrong");
  a_dec_vec: assert property (sel == PEU_TK_DEC // RL16
    |=> haddr == $past(base) + $past(dec_vec_in))
    else $error("decrementer vector wrong");
  a_brk_vec: assert property (sel inside {PEU_TK_NMBRK, PEU_TK_MBRK} // RL16
    |=> haddr == $past(base) + $past(brk_vec_in))
    else $error("breakpoint vector wrong");
  a_sync_vec: assert property (sel == PEU_TK_SYNC && sync_cause_in != PEU_SC_MCHK // RL16
    |=> haddr == $past(base) + $past(sync_vec_in))
    else $error("fault vector wrong");

  // ===========================================================================
  // scenarios
  c_reset_take: cover property (sel == PEU_TK_RESET);
  c_nm_take: cover property (sel == PEU_TK_NMBRK);
  c_ext_take: cover property (sel == PEU_TK_EXT);
  c_sync_take: cover property (sel == PEU_TK_SYNC ##1 take);
  c_mbrk_take: cover property (sel == PEU_TK_MBRK);
endmodule // peu_core
`default_nettype wire

// ===== dv/peu_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================
// pipeline head model: presents one faulting instruction at a time
module peu_pipe_model
  import peu_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               stall_in,
  output var  logic               sync_valid_out,
  output var  peu_sync_cause_t    sync_cause_out,
  output var  logic [PEU_AW-1:0]  sync_pc_out,
  output var  logic [PEU_AW-1:0]  next_pc_out,
  output var  logic               head_ready_out
);
  initial begin
    sync_valid_out = 1'b0;
    sync_cause_out = PEU_SC_MCHK;
    sync_pc_out = 32'h0000_0000;
    next_pc_out = 32'h0000_0000;
  end
  // head stays unready while older work still retires
  always_comb head_ready_out = !stall_in;
  // fault shown for one cycle only so it is never taken twice
  task automatic fault(input peu_sync_cause_t c, input logic [PEU_AW-1:0] pc);
    @(posedge sys_clk_in);
    sync_valid_out <= 1'b1;
    sync_cause_out <= c;
    sync_pc_out <= pc;
    next_pc_out <= pc + 32'h0000_0100;
    @(posedge sys_clk_in);
    sync_valid_out <= 1'b0;
    sync_pc_out <= ~pc;
  endtask
endmodule // peu_pipe_model
`default_nettype wire

// ===== dv/peu_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================
// bench top
module peu_core_tb_top;
  import peu_pkg::*;
  logic clk, rstn, stall, mwr, sv, hr, take, flush, ep, dp;
  logic [4:0] pins;
  logic [31:0] mwd, svec, spc, npc, ha, spco, sms, machine_state_register, v;
  peu_sync_cause_t sc;
  int miscompares = 0, check_count = 0, takes = 0;
  localparam logic [31:0] DVEC = 32'h0000_0900, BVEC = 32'h0000_1c00;
  peu_pipe_model pipe_i (.sys_clk_in(clk), .stall_in(stall), .sync_valid_out(sv),
    .sync_cause_out(sc), .sync_pc_out(spc), .next_pc_out(npc), .head_ready_out(hr));
  peu_core peu_core_i (.sys_clk_in(clk), .resetn_in(rstn), .reset_req_in(pins[0]),
    .nm_brk_in(pins[1]), .ext_irq_in(pins[2]), .dec_irq_in(pins[3]), .m_brk_in(pins[4]),
    .sync_valid_in(sv), .sync_cause_in(sc), .sync_pc_in(spc), .next_pc_in(npc),
    .sync_vec_in(svec), .dec_vec_in(DVEC), .brk_vec_in(BVEC), .head_ready_in(hr),
    .msr_wr_in(mwr), .msr_wdata_in(mwd), .take_out(take), .flush_out(flush),
    .handler_addr_out(ha), .saved_program_counter_out(spco),
    .saved_machine_state_out(sms), .machine_state_register_out(machine_state_register),
    .ext_pending_out(ep), .dec_pending_out(dp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (take === 1'b1) takes <= takes + 1;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] base(input logic ip);
    return ip ? PEU_BASE_HIGH : PEU_BASE_LOW;
  endfunction
  task automatic set_msr(input logic ee, input logic ip, input logic ri);
    v = 32'h0000_0000;
    v[PEU_MSR_EE_POS] = ee;
    v[PEU_MSR_IP_POS] = ip;
    v[PEU_MSR_RI_POS] = ri;
    @(posedge clk);
    mwr <= 1'b1;
    mwd <= v;
    @(posedge clk);
    mwr <= 1'b0;
    #1 chk("msr", v, machine_state_register);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pins[i] <= 1'b1;
    @(posedge clk);
    pins[i] <= 1'b0;
  endtask
  task automatic wait_take(input int n);
    int i;
    i = 0;
    while (take !== 1'b1 && i < n) begin
      @(posedge clk);
      #1 i++;
    end
  endtask
  task automatic t_sync;
    logic [31:0] pc, e;
    for (int c = 0; c < 14; c++) begin
      set_msr(1'b1, c[0], c[1]);
      @(posedge clk);
      svec <= 32'h0000_0300 + (32'(c) << 8);
      pc = 32'h0000_2000 + 32'(c) * 16;
      pipe_i.fault(peu_sync_cause_t'(c), pc);
      e = (c == 13) ? pc + PEU_PC_STEP : (c >= 10) ? pc + 32'h0000_0100 : pc;
      #1 chk("take", 1, take);
      chk("flush", 1, flush);
      chk("spc", e, spco);
      chk("hand", base(c[0]) + ((c == 0) ? PEU_VEC_MCHK : svec), ha);
      chk("sms", v, sms);
      chk("msr", v & ~(32'h1 << PEU_MSR_EE_POS), machine_state_register);
      @(posedge clk);
      #1 chk("take", 0, take);
    end
  endtask
  task automatic t_ext_dec;
    int t0;
    set_msr(1'b0, 1'b0, 1'b1);
    pulse(2);
    pulse(3);
    t0 = takes;
    repeat (6) @(posedge clk);
    #1 chk("ntk", t0, takes);
    chk("pend", 2'b11, {ep, dp});
    @(posedge clk);
    stall <= 1'b1;
    set_msr(1'b1, 1'b0, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk("ntk", t0, takes);
    @(posedge clk);
    stall <= 1'b0;
    wait_take(8);
    chk("take", 1, take);
    chk("hand", PEU_VEC_EXT, ha);
    chk("spc", npc, spco);
    repeat (5) @(posedge clk);
    #1 chk("ntk", t0 + 1, takes);
    chk("pend", 2'b01, {ep, dp});
    set_msr(1'b1, 1'b1, 1'b1);
    wait_take(8);
    chk("take", 1, take);
    chk("hand", PEU_BASE_HIGH + DVEC, ha);
    #1 chk("pend", 2'b00, {ep, dp});
  endtask
  task automatic t_brk;
    int t0;
    set_msr(1'b1, 1'b0, 1'b0);
    t0 = takes;
    pulse(4);
    repeat (8) @(posedge clk);
    #1 chk("ntk", t0, takes);
    set_msr(1'b1, 1'b0, 1'b1);
    pulse(4);
    wait_take(8);
    chk("take", 1, take);
    chk("hand", BVEC, ha);
    set_msr(1'b1, 1'b0, 1'b0);
    t0 = takes;
    pipe_i.fault(PEU_SC_TRAP, 32'h0000_3000);
    pulse(1);
    wait_take(8);
    chk("take", 1, take);
    chk("spc", 32'h0000_3100, spco);
    repeat (3) @(posedge clk);
    #1 chk("ntk", t0 + 2, takes);
    pulse(0);
    wait_take(8);
    chk("take", 1, take);
    chk("hand", PEU_VEC_RESET, ha);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    pins = 5'h00;
    stall = 1'b0;
    mwr = 1'b0;
    mwd = 32'h0000_0000;
    svec = 32'h0000_0000;
    repeat (4) @(posedge clk);
    #1 chk("msr0", PEU_MSR_RESET, machine_state_register);
    chk("tk0", 0, {take, flush, ep, dp});
    chk("ha0", 0, ha);
    @(posedge clk);
    rstn <= 1'b1;
    t_sync();
    t_ext_dec();
    t_brk();
    wrap_up();
  end
endmodule // peu_core_tb_top
`default_nettype wire
